// ### rtl/trace_capture.sv
// trace capture block: frame builder, capture control, frame buffer and APB slave
`timescale 1ns/1ps
`default_nettype none
// Function
// - address frame and data frame per bus cycle
// - queue-only frame when queue is active
// - buffer keeps newest 1023 frames
// - frame holds all documented fields
// - bus phase and queue share one frame
// - reset: unconditional capture, empty buffer
// - code pointer change empties buffer
// - code pointer change zeroes both timers
// - trace command clears at next entry
// - unconditional mode captures every run
// - conditional: start match on, stop off
// - conditional initial state forced or kept
// - disable mode captures nothing
// - count first-byte queue frames as instructions
// - prefix bytes count as separate instructions
// - marker set after stop or break
// - frame kind: address, data, queue, stop
// - queue state keeps four conditions
module trace_capture
   import trace_pkg::*;
#(
   parameter int DEPTH = trace_pkg::FRAME_DEPTH,
   parameter int AW    = trace_pkg::FRAME_AW
) (
   input  wire logic                      core_clk,
   input  wire logic                      rst_b,
   input  wire logic                      emuRun,
   input  wire trace_pkg::cpu_bus_t       cpuBus,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [trace_pkg::APB_AW-1:0] paddr,
   input  wire logic [trace_pkg::APB_DW-1:0] pwdata,
   output logic                           pready,
   output logic [trace_pkg::APB_DW-1:0]   prdata,
   output logic                           pslverr,
   output logic                           captureOn
);
   import trace_pkg::*;

   localparam logic [AW-1:0] LAST_SLOT  = AW'(DEPTH - 1);
   localparam logic [AW-1:0] FULL_COUNT = AW'(DEPTH);
   localparam logic [AW:0]   DEPTH_WIDE = (AW+1)'(DEPTH);

   // ***********************************************************
   // state
   // ***********************************************************
   trace_mode_t        traceMode;
   init_opt_t          initOpt;
   logic [MATCH_W-1:0] startMatch;
   logic [MATCH_W-1:0] stopMatch;
   logic               condOn;
   logic               emuPrev;
   logic               pendingCmd;
   logic               markPending;
   logic [AW-1:0]      writePtr;
   logic [AW-1:0]      fill;
   logic [AW-1:0]      readIndex;
   logic [TIMER_W-1:0] instrCount;
   logic [TIMER_W-1:0] elapsedLow;
   logic [TIMER_W-1:0] elapsedHigh;
   frame_t             newFrame;
   frame_t             readFrame;
   logic [APB_DW-1:0]  readWord;
   logic [APB_DW-1:0]  statusWord;
   logic               mapped;

   // ***********************************************************
   // bus decode
   // ***********************************************************
   wire logic apbWrite   = psel & penable & pready & pwrite;
   wire logic next_ready = psel & penable & ~pready;
   wire logic selCtrl    = (paddr == CTRL_OFS);
   wire logic selStart   = (paddr == START_MATCH_OFS);
   wire logic selStop    = (paddr == STOP_MATCH_OFS);
   wire logic selCommand = (paddr == COMMAND_OFS);
   wire logic selIndex   = (paddr == READ_INDEX_OFS);

   // ***********************************************************
   // emulation entry and exit, clear sources
   // ***********************************************************
   wire logic entry      = emuRun & ~emuPrev;
   wire logic leave      = ~emuRun & emuPrev;
   wire logic entryClear = entry & pendingCmd;
   wire logic codeChange = apbWrite & selCommand & pwdata[CMD_CHANGE_BIT];
   wire logic clearAll   = codeChange | entryClear;
   wire logic ctrlWrite  = apbWrite & selCtrl;

   // ***********************************************************
   // capture enable
   // ***********************************************************
   wire logic startHit      = cpuBus.addrValid & (cpuBus.addrData == startMatch);
   wire logic stopHit       = cpuBus.addrValid & (cpuBus.addrData == stopMatch);
   wire logic modeAlways    = (traceMode == MODE_ALWAYS);
   wire logic modeCond      = (traceMode == MODE_CONDITIONAL);
   wire logic captureActive = modeAlways | (modeCond & (condOn | startHit));
   wire logic queueActive   = (cpuBus.queueState != QUEUE_IDLE);
   wire logic busEvent      = cpuBus.addrValid | cpuBus.dataValid | queueActive;
   wire logic busFrame      = emuRun & captureActive & busEvent;
   // a break closes the run with one stop frame while capture was on
   wire logic stopFrame     = leave & captureOn;
   wire logic frameWrite    = (busFrame | stopFrame) & ~clearAll;
   wire logic firstByte     = ~stopFrame & (cpuBus.queueState == QUEUE_FIRST);
   wire logic setMark       = leave | (captureOn & ~captureActive);

   // ***********************************************************
   // frame builder
   // ***********************************************************
   always_comb begin
      newFrame            = '0;
      newFrame.addrData   = cpuBus.addrData;
      newFrame.busState   = cpuBus.busState;
      newFrame.queueState = cpuBus.queueState;
      newFrame.queueDepth = cpuBus.queueDepth;
      newFrame.mark       = markPending;
      if (stopFrame) begin
         newFrame.frameKind = KIND_STOP;
      end else if (cpuBus.addrValid) begin
         newFrame.frameKind = KIND_ADDRESS;
      end else if (cpuBus.dataValid) begin
         newFrame.frameKind = KIND_DATA;
      end else begin
         newFrame.frameKind = KIND_QUEUE;
      end
   end

   // ***********************************************************
   // buffer addressing
   // ***********************************************************
   wire logic          full      = (fill == FULL_COUNT);
   wire logic [AW-1:0] oldest    = full ? writePtr : '0;
   wire logic [AW:0]   rdSum     = {1'b0, oldest} + {1'b0, readIndex};
   wire logic [AW:0]   rdWrapped = rdSum - DEPTH_WIDE;
   wire logic [AW-1:0] rdAddr    = (rdSum >= DEPTH_WIDE) ? rdWrapped[AW-1:0] : rdSum[AW-1:0];
   wire logic [AW-1:0] ptrNext   = (writePtr == LAST_SLOT) ? '0 : writePtr + 1'b1;

   trace_frame_store #(
      .DEPTH (DEPTH),
      .AW    (AW)
   ) trace_frame_store_inst (
      .core_clk (core_clk),
      .wrEn     (frameWrite),
      .wrAddr   (writePtr),
      .wrData   (newFrame),
      .rdAddr   (rdAddr),
      .rdData   (readFrame)
   );

   elapsed_timer #(
      .WIDTH (TIMER_W)
   ) elapsed_timer_inst (
      .core_clk  (core_clk),
      .rst_b     (rst_b),
      .clear     (clearAll),
      .run       (emuRun),
      .countLow  (elapsedLow),
      .countHigh (elapsedHigh)
   );

   // ***********************************************************
   // write pointer and fill
   // ***********************************************************
   always_ff @(posedge core_clk) begin
      if (!rst_b || clearAll) begin
         writePtr <= '0;
         fill     <= '0;
      end else if (frameWrite) begin
         writePtr <= ptrNext;
         if (!full) begin
            fill <= fill + 1'b1;
         end
      end
   end

   // prefix bytes report first-byte status too, so each adds one
   always_ff @(posedge core_clk) begin
      if (!rst_b || clearAll) begin
         instrCount <= '0;
      end else if (frameWrite && firstByte) begin
         instrCount <= instrCount + 1'b1;
      end
   end

   // ***********************************************************
   // capture control
   // ***********************************************************
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         condOn <= 1'b0;
      end else if (entryClear && modeCond && initOpt == INIT_ON) begin
         condOn <= 1'b1;
      end else if (entryClear && modeCond && initOpt == INIT_OFF) begin
         condOn <= 1'b0;
      end else if (modeCond && emuRun && stopHit) begin
         condOn <= 1'b0;
      end else if (modeCond && emuRun && startHit) begin
         condOn <= 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         emuPrev     <= 1'b0;
         captureOn   <= CAPTURE_ON_RESET;
         markPending <= 1'b0;
         pendingCmd  <= 1'b0;
      end else begin
         emuPrev     <= emuRun;
         captureOn   <= captureActive;
         // a new mark wins over the frame that consumes the old one
         markPending <= setMark | (markPending & ~frameWrite);
         pendingCmd  <= ctrlWrite | (pendingCmd & ~entry);
      end
   end

   // ***********************************************************
   // software registers
   // ***********************************************************
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         traceMode  <= MODE_RESET;
         initOpt    <= INIT_RESET;
         startMatch <= MATCH_RESET;
         stopMatch  <= MATCH_RESET;
         readIndex  <= '0;
      end else if (apbWrite) begin
         if (selCtrl) begin
            traceMode <= trace_mode_t'(pwdata[CTRL_MODE_LSB +: 2]);
            initOpt   <= init_opt_t'(pwdata[CTRL_INIT_LSB +: 2]);
         end
         if (selStart) begin
            startMatch <= pwdata[MATCH_W-1:0];
         end
         if (selStop) begin
            stopMatch <= pwdata[MATCH_W-1:0];
         end
         if (selIndex) begin
            readIndex <= pwdata[AW-1:0];
         end
      end
   end

   // ***********************************************************
   // read mux
   // ***********************************************************
   always_comb begin
      statusWord                                = '0;
      statusWord[STAT_FILL_LSB +: AW]           = fill;
      statusWord[STAT_FULL_BIT]                 = full;
      statusWord[STAT_CAPTURE_BIT]              = captureOn;
      statusWord[STAT_PENDING_BIT]              = pendingCmd;
      statusWord[STAT_MARK_BIT]                 = markPending;
   end

   always_comb begin
      readWord = '0;
      mapped   = 1'b1;
      if (paddr == CTRL_OFS) begin
         readWord[CTRL_MODE_LSB +: 2] = traceMode;
         readWord[CTRL_INIT_LSB +: 2] = initOpt;
      end else if (paddr == START_MATCH_OFS) begin
         readWord[MATCH_W-1:0] = startMatch;
      end else if (paddr == STOP_MATCH_OFS) begin
         readWord[MATCH_W-1:0] = stopMatch;
      end else if (paddr == COMMAND_OFS) begin
         readWord = '0;
      end else if (paddr == STATUS_OFS) begin
         readWord = statusWord;
      end else if (paddr == INSTR_COUNT_OFS) begin
         readWord = instrCount;
      end else if (paddr == ELAPSED_LOW_OFS) begin
         readWord = elapsedLow;
      end else if (paddr == ELAPSED_HIGH_OFS) begin
         readWord = elapsedHigh;
      end else if (paddr == READ_INDEX_OFS) begin
         readWord[AW-1:0] = readIndex;
      end else if (paddr == FRAME_DATA_OFS) begin
         readWord[$bits(frame_t)-1:0] = readFrame;
      end else begin
         mapped = 1'b0;
      end
   end

   // ***********************************************************
   // bus answer: one wait state, all outputs registered
   // ***********************************************************
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         pready  <= 1'b0;
         prdata  <= '0;
         pslverr <= 1'b0;
      end else begin
         pready  <= next_ready;
         pslverr <= next_ready & ~mapped;
         if (next_ready && !pwrite) begin
            prdata <= readWord;
         end
      end
   end

   // ***********************************************************
   // checks
   // ***********************************************************
   // witness for the marker check: a stop frame was the last capture event
   logic breakSeen;
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         breakSeen <= 1'b0;
      end else if (stopFrame) begin
         breakSeen <= 1'b1;
      end else if (frameWrite) begin
         breakSeen <= 1'b0;
      end
   end

   reset_state_a: assert property (@(posedge core_clk) !rst_b |=> fill == '0 && traceMode == MODE_ALWAYS)
      else $error("reset did not give empty buffer and unconditional capture");
   clear_empties_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      codeChange |=> fill == '0 && writePtr == '0)
      else $error("code pointer change left frames in buffer");
   timer_clear_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      clearAll |=> elapsedLow == '0 && elapsedHigh == '0)
      else $error("timers not zeroed on clear");
   cmd_arm_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      ctrlWrite |=> pendingCmd)
      else $error("trace command not held for next entry");
   entry_clear_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      pendingCmd && entry |=> fill == '0 && elapsedLow == '0 && instrCount == '0)
      else $error("trace command did not clear at emulation entry");
   addr_frame_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      emuRun && modeAlways && cpuBus.addrValid && !clearAll |-> frameWrite && newFrame.frameKind == KIND_ADDRESS)
      else $error("address phase not captured as address frame");
   queue_frame_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      busFrame && !cpuBus.addrValid && !cpuBus.dataValid |-> newFrame.frameKind == KIND_QUEUE)
      else $error("queue-only activity mislabelled");
   fill_cap_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      full && frameWrite |=> full && writePtr == $past(ptrNext))
      else $error("full buffer did not overwrite oldest");
   ptr_wrap_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      frameWrite && writePtr == LAST_SLOT |=> writePtr == '0)
      else $error("write pointer did not wrap");
   off_mode_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      traceMode == MODE_OFF && !captureOn && !clearAll |=> $stable(writePtr))
      else $error("frame captured in disable mode");
   cond_stop_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      modeCond && emuRun && stopHit && !entryClear |=>
         !condOn ##1 (!captureOn || $past(startHit) || $past(modeAlways)))
      else $error("stop match did not turn capture off");
   init_on_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      entryClear && modeCond && initOpt == INIT_ON |=> condOn)
      else $error("initial on option ignored");
   instr_count_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      frameWrite && firstByte && !clearAll |=> instrCount == $past(instrCount) + 1'b1)
      else $error("first-byte frame not counted");
   mark_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      frameWrite && !stopFrame && breakSeen |-> newFrame.mark)
      else $error("frame after a break lacks its marker");

   wrap_c: cover property (@(posedge core_clk) disable iff (!rst_b) full && frameWrite);
   cond_on_c: cover property (@(posedge core_clk) disable iff (!rst_b) modeCond && emuRun && startHit);
   stop_frame_c: cover property (@(posedge core_clk) disable iff (!rst_b) stopFrame);
   frame_read_c: cover property (@(posedge core_clk) disable iff (!rst_b)
      next_ready && !pwrite && paddr == FRAME_DATA_OFS);

endmodule
`default_nettype wire

// ### rtl/trace_pkg.sv
// shared types, register map and reset values for the trace capture block
package trace_pkg;

   // ***********************************************************
   // sizes
   // ***********************************************************
   localparam int FRAME_DEPTH  = 1023;
   localparam int FRAME_AW     = 10;
   localparam int APB_AW       = 8;
   localparam int APB_DW       = 32;
   localparam int TIMER_W      = 32;
   localparam int MATCH_W      = 20;

   // ***********************************************************
   // register offsets (byte addresses)
   // ***********************************************************
   localparam logic [APB_AW-1:0] CTRL_OFS         = 8'h00;
   localparam logic [APB_AW-1:0] START_MATCH_OFS  = 8'h04;
   localparam logic [APB_AW-1:0] STOP_MATCH_OFS   = 8'h08;
   localparam logic [APB_AW-1:0] COMMAND_OFS      = 8'h0c;
   localparam logic [APB_AW-1:0] STATUS_OFS       = 8'h10;
   localparam logic [APB_AW-1:0] INSTR_COUNT_OFS  = 8'h14;
   localparam logic [APB_AW-1:0] ELAPSED_LOW_OFS  = 8'h18;
   localparam logic [APB_AW-1:0] ELAPSED_HIGH_OFS = 8'h1c;
   localparam logic [APB_AW-1:0] READ_INDEX_OFS   = 8'h20;
   localparam logic [APB_AW-1:0] FRAME_DATA_OFS   = 8'h24;

   // ***********************************************************
   // field positions
   // ***********************************************************
   localparam int CTRL_MODE_LSB    = 0;
   localparam int CTRL_INIT_LSB    = 2;
   localparam int CMD_CHANGE_BIT   = 0;
   localparam int STAT_FILL_LSB    = 0;
   localparam int STAT_FULL_BIT    = 10;
   localparam int STAT_CAPTURE_BIT = 11;
   localparam int STAT_PENDING_BIT = 12;
   localparam int STAT_MARK_BIT    = 13;

   // ***********************************************************
   // types
   // ***********************************************************
   typedef enum logic [1:0] {MODE_ALWAYS, MODE_CONDITIONAL, MODE_OFF} trace_mode_t;
   typedef enum logic [1:0] {INIT_KEEP, INIT_ON, INIT_OFF} init_opt_t;
   typedef enum logic [1:0] {KIND_ADDRESS, KIND_DATA, KIND_QUEUE, KIND_STOP} frame_kind_t;
   // bit 0 is queue_state_bit0, bit 1 is queue_state_bit1
   typedef enum logic [1:0] {
      QUEUE_IDLE    = 2'h0,
      QUEUE_FIRST   = 2'h1,
      QUEUE_EMPTIED = 2'h2,
      QUEUE_NEXT    = 2'h3
   } queue_state_t;

   typedef struct packed {
      logic         mark;
      frame_kind_t  frameKind;
      logic [2:0]   queueDepth;
      queue_state_t queueState;
      logic [2:0]   busState;
      logic [19:0]  addrData;
   } frame_t;

   typedef struct packed {
      logic         addrValid;
      logic         dataValid;
      logic [19:0]  addrData;
      logic [2:0]   busState;
      queue_state_t queueState;
      logic [2:0]   queueDepth;
   } cpu_bus_t;

   // ***********************************************************
   // reset values
   // ***********************************************************
   localparam trace_mode_t          MODE_RESET       = MODE_ALWAYS;
   localparam init_opt_t            INIT_RESET       = INIT_KEEP;
   localparam logic [MATCH_W-1:0]   MATCH_RESET      = 20'h00000;
   localparam logic                 CAPTURE_ON_RESET = 1'b1;

endpackage

// ### rtl/elapsed_timer.sv
// low and high elapsed-time counters that run during emulation
`timescale 1ns/1ps
`default_nettype none
module elapsed_timer #(
   parameter int WIDTH = 32
) (
   input  wire logic             core_clk,
   input  wire logic             rst_b,
   input  wire logic             clear,
   input  wire logic             run,
   output logic [WIDTH-1:0]      countLow,
   output logic [WIDTH-1:0]      countHigh
);

   always_ff @(posedge core_clk) begin
      if (!rst_b || clear) begin
         countLow  <= '0;
         countHigh <= '0;
      end else if (run) begin
         countLow <= countLow + 1'b1;
         // high word carries out of the low word
         if (&countLow) begin
            countHigh <= countHigh + 1'b1;
         end
      end
   end

endmodule
`default_nettype wire

// ### rtl/trace_frame_store.sv
// frame memory with one write port and one registered read port
`timescale 1ns/1ps
`default_nettype none
module trace_frame_store
   import trace_pkg::*;
#(
   parameter int DEPTH = 1023,
   parameter int AW    = 10
) (
   input  wire logic             core_clk,
   input  wire logic             wrEn,
   input  wire logic [AW-1:0]    wrAddr,
   input  wire trace_pkg::frame_t wrData,
   input  wire logic [AW-1:0]    rdAddr,
   output var trace_pkg::frame_t rdData
);

   frame_t mem [DEPTH];

   // no reset on the array: empty is tracked by the fill count outside
   always_ff @(posedge core_clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
   end

endmodule
`default_nettype wire

// ### test/cpu_bus_model.sv
// far-side model: drives one bus phase or queue event per request
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model (
   input  wire logic                    core_clk,
   input  wire logic                    req,
   input  wire logic [1:0]              phase,
   input  wire logic [19:0]             value,
   input  wire trace_pkg::queue_state_t qs,
   output var trace_pkg::cpu_bus_t      cpuBus
);
   import trace_pkg::*;
   // idle address/data and depth lines show the inverse value so a stale frame cannot pass unseen
   always_ff @(posedge core_clk) begin
      cpuBus.addrValid  <= req & (phase == 2'h1);
      cpuBus.dataValid  <= req & (phase == 2'h2);
      cpuBus.addrData   <= req ? value : ~value;
      cpuBus.busState   <= req ? 3'h4 : 3'h7;
      cpuBus.queueState <= req ? qs : QUEUE_IDLE;
      cpuBus.queueDepth <= req ? 3'h2 : 3'h5;
   end
endmodule
`default_nettype wire

// ### test/trace_capture_tb_top.sv
// self-checking bench for the trace capture block
`timescale 1ns/1ps
`default_nettype none
module trace_capture_tb_top;
   import trace_pkg::*;
   logic         core_clk = '0, rst_b = '0, emuRun = '0, psel = '0, penable = '0, pwrite = '0, req = '0;
   logic         pready, pslverr, captureOn, err;
   logic [7:0]   paddr = '0;
   logic [31:0]  pwdata = '0, prdata;
   logic [1:0]   phase = '0;
   logic [19:0]  value = '0;
   queue_state_t qs = QUEUE_IDLE;
   cpu_bus_t     cpuBus;
   int           error_cnt = 0, n_tests = 0, cycles = 0;
   // small depth so wrap-around is reached quickly
   trace_capture #(.DEPTH(7), .AW(3)) trace_capture_inst (.core_clk, .rst_b, .emuRun, .cpuBus, .psel, .penable,
      .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .captureOn);
   cpu_bus_model cpu_bus_model_inst (.core_clk, .req, .phase, .value, .qs, .cpuBus);
   initial forever #5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         error_cnt++;
         $display("wrong value at %0t: timeout", $time);
         test_done();
      end
   end
   task automatic test_done();
      if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'h1;
      do begin
         @(posedge core_clk);
      end while (pready !== 1'h1);
      r = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      // one idle edge so the next call never reassigns psel in this time step
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] r;
      apb(1'h0, a, '0, r);
      chk(r & m, e);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(1'h1, a, d, r);
   endtask
   task automatic fd(input logic [31:0] idx, input logic [31:0] m, input logic [31:0] e);
      wr(READ_INDEX_OFS, idx);
      rd(FRAME_DATA_OFS, m, e);
   endtask
   task automatic ev(input logic [1:0] p, input queue_state_t q, input logic [19:0] v);
      req <= 1'h1;
      phase <= p;
      qs <= q;
      value <= v;
      @(posedge core_clk);
      req <= 1'h0;
      repeat (2) @(posedge core_clk);
   endtask
   task automatic emu(input logic on);
      emuRun <= on;
      repeat (3) @(posedge core_clk);
   endtask
   // frame word with the model's fixed bus state 4 and depth 2
   function automatic logic [31:0] fr(logic m, logic [1:0] k, logic [1:0] q, logic [19:0] v);
      return {1'h0, m, k, 3'h2, q, 3'h4, v};
   endfunction
   // ***********************************************************
   // scenarios
   // ***********************************************************
   task automatic t_reset();
      chk({31'h0, captureOn}, 32'h1);
      rd(STATUS_OFS, 32'hfff, 32'h800);
      rd(8'h30, 32'hffffffff, 32'h0);
      chk({31'h0, err}, 32'h1);
   endtask
   task automatic t_capture();
      emu(1'h1);
      ev(2'h1, QUEUE_FIRST, 20'h12345);
      ev(2'h2, QUEUE_IDLE, 20'h000ab);
      ev(2'h0, QUEUE_FIRST, 20'h0);
      ev(2'h0, QUEUE_FIRST, 20'h0);
      emu(1'h0);
      rd(STATUS_OFS, 32'h7ff, 32'h5);
      rd(INSTR_COUNT_OFS, 32'hffffffff, 32'h3);
      fd(0, 32'h7fffffff, fr(1'h0, 2'h0, 2'h1, 20'h12345));
      fd(1, 32'h7fffffff, fr(1'h0, 2'h1, 2'h0, 20'h000ab));
      fd(2, 32'h31800000, 32'h20800000);
      fd(4, 32'h30000000, 32'h30000000);
      ev(2'h1, QUEUE_IDLE, 20'h00777);
      rd(STATUS_OFS, 32'h7ff, 32'h5);
      emu(1'h1);
      ev(2'h1, QUEUE_IDLE, 20'h00001);
      emu(1'h0);
      fd(5, 32'h70000000, 32'h40000000);
      emu(1'h1);
      ev(2'h1, QUEUE_EMPTIED, 20'h00002);
      emu(1'h0);
      rd(STATUS_OFS, 32'h7ff, 32'h407);
      fd(0, 32'h7fffffff, fr(1'h0, 2'h2, 2'h1, 20'h00000));
      fd(5, 32'h71800000, 32'h41000000);
   endtask
   task automatic t_clear();
      wr(COMMAND_OFS, 32'h1);
      rd(STATUS_OFS, 32'h7ff, 32'h0);
      rd(INSTR_COUNT_OFS, 32'hffffffff, 32'h0);
      rd(ELAPSED_LOW_OFS, 32'hffffffff, 32'h0);
      rd(ELAPSED_HIGH_OFS, 32'hffffffff, 32'h0);
   endtask
   task automatic t_disable();
      emu(1'h1);
      ev(2'h1, QUEUE_IDLE, 20'h00010);
      emu(1'h0);
      wr(CTRL_OFS, 32'h2);
      rd(STATUS_OFS, 32'h7ff, 32'h2);
      emu(1'h1);
      ev(2'h1, QUEUE_FIRST, 20'h00020);
      emu(1'h0);
      rd(STATUS_OFS, 32'h7ff, 32'h0);
   endtask
   task automatic t_cond();
      wr(START_MATCH_OFS, 32'h00100);
      wr(STOP_MATCH_OFS, 32'h00200);
      wr(CTRL_OFS, 32'h9);
      emu(1'h1);
      ev(2'h1, QUEUE_IDLE, 20'h00050);
      ev(2'h1, QUEUE_IDLE, 20'h00100);
      ev(2'h2, QUEUE_IDLE, 20'h00033);
      ev(2'h1, QUEUE_IDLE, 20'h00200);
      ev(2'h1, QUEUE_IDLE, 20'h00300);
      rd(STATUS_OFS, 32'h27ff, 32'h2003);
      chk({31'h0, captureOn}, 32'h0);
      emu(1'h0);
      wr(CTRL_OFS, 32'h5);
      emu(1'h1);
      ev(2'h1, QUEUE_IDLE, 20'h00050);
      emu(1'h0);
      rd(STATUS_OFS, 32'h7ff, 32'h2);
   endtask
   initial begin
      repeat (12) @(posedge core_clk);
      rst_b <= 1'h1;
      @(posedge core_clk);
      t_reset();
      t_capture();
      t_clear();
      t_disable();
      t_cond();
      test_done();
   end
endmodule
`default_nettype wire
